// ===== pkg/sfc_pkg.sv
// Shared constants and types for the serial flash controller
package sfc_pkg;
	localparam int          XADDR_W             = 17;
	localparam int          CACHE_BYTES         = 32;
	localparam int          CACHE_IDX_W         = 5;
	localparam int          CMD_BUF_BYTES       = 8;
	localparam int          SAMPLE_PIPE         = 3;
	localparam logic [7:0]  SINGLE_READ_OPCODE  = 8'h0B;
	localparam logic [7:0]  BYTE_PROGRAM_OPCODE = 8'h02;
	localparam logic [7:0]  DUMMY_BYTE          = 8'h00;
	localparam logic [7:0]  DONT_CARE_BYTE      = 8'hFF;
	localparam logic [7:0]  DISABLED_READ_BYTE  = 8'hFF;
	localparam logic [1:0]  LAST_ADDR_BYTE      = 2'h2;
	localparam logic [3:0]  SINGLE_CLOCKS       = 4'h8;
	localparam logic [3:0]  DUAL_CLOCKS         = 4'h4;
	localparam logic [5:0]  CACHE_FULL          = 6'h20;
	localparam logic [63:0] BUF_RESET           = 64'h0000_0000_0000_0000;

	typedef enum logic [1:0]
	{
		OP_SINGLE = 2'h0,
		OP_DUAL   = 2'h1,
		OP_END    = 2'h2
	} link_op_type;
endpackage : sfc_pkg

// ===== pkg/sfc_xfer_if.sv
// Byte transfer handshake between core and link domains
`timescale 1ns/1ns
interface sfc_xfer_if;
	import sfc_pkg::*;
	logic        req_tgl;
	link_op_type op;
	logic [7:0]  tx_byte;
	logic        ack_tgl;
	logic [7:0]  rx_byte;
	modport core (output req_tgl, output op, output tx_byte, input ack_tgl, input rx_byte);
	modport link (input req_tgl, input op, input tx_byte, output ack_tgl, output rx_byte);
endinterface : sfc_xfer_if

// ===== logic/sfc_sync.sv
// Two flip-flop synchroniser
`timescale 1ns/1ns
module sfc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,   // Destination clock
	input  wire logic             rst_i,   // Async reset
	input  wire logic [WIDTH-1:0] async_i, // Foreign level
	output logic      [WIDTH-1:0] sync_o   // Synchronised level
);
	logic [WIDTH-1:0] meta;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("sfc_sync: WIDTH must be at least one");
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meta   <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule : sfc_sync

// ===== logic/sfc_shifter.sv
// Link-clock byte shifter driving the flash pins
`timescale 1ns/1ns
module sfc_shifter
	import sfc_pkg::*;
(
	input  wire logic  link_clk_i, // Link clock
	input  wire logic  rst_i,      // Async reset
	input  wire logic  req_seen_i, // Synced request toggle
	input  wire logic [1:0] pins_i, // Synced {in line, out line}
	sfc_xfer_if.link   xfer,       // Byte handshake
	output logic       sck_o,      // Serial clock
	output logic       cs_n_o,     // Chip select
	output logic       do_o,       // Out line value
	output logic       do_oe_n_o   // Out line enable
);
	logic                   req_last;
	logic                   running;
	logic                   dual;
	logic                   start;
	logic                   rise;
	logic [3:0]             remaining;
	logic [7:0]             shreg;
	logic [7:0]             rxs;
	logic [SAMPLE_PIPE-1:0] strobe;

	assign start = (req_seen_i != req_last) && !running;
	assign rise  = running && !sck_o && (remaining != 4'h0);

	always_ff @(posedge link_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			req_last     <= 1'b0;
			running      <= 1'b0;
			dual         <= 1'b0;
			remaining    <= 4'h0;
			shreg        <= 8'h00;
			sck_o        <= 1'b0;
			cs_n_o       <= 1'b1;
			do_o         <= 1'b0;
			do_oe_n_o    <= 1'b0;
			xfer.ack_tgl <= 1'b0;
			xfer.rx_byte <= 8'h00;
		end
		else if (start)
		begin
			req_last <= req_seen_i;
			if (xfer.op == OP_END)
			begin
				cs_n_o       <= 1'b1;
				do_oe_n_o    <= 1'b0;
				xfer.ack_tgl <= ~xfer.ack_tgl;
			end
			else
			begin
				cs_n_o    <= 1'b0;
				shreg     <= xfer.tx_byte;
				do_o      <= xfer.tx_byte[7];
				running   <= 1'b1;
				// dual bytes take four clocks, line released
				dual      <= xfer.op == OP_DUAL;
				do_oe_n_o <= xfer.op == OP_DUAL;
				remaining <= (xfer.op == OP_DUAL) ? DUAL_CLOCKS : SINGLE_CLOCKS;
			end
		end
		else if (running)
		begin
			if (sck_o)
			begin
				sck_o <= 1'b0;
				shreg <= {shreg[6:0], 1'b0};
				do_o  <= shreg[6];
			end
			else if (remaining != 4'h0)
			begin
				sck_o     <= 1'b1;
				remaining <= remaining - 4'h1;
			end
			else if (strobe == '0)
			begin
				running      <= 1'b0;
				xfer.rx_byte <= rxs;
				xfer.ack_tgl <= ~xfer.ack_tgl;
			end
		end
	end

	// Pins arrive two flops late, so the sample point trails the edge
	always_ff @(posedge link_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			strobe <= '0;
			rxs    <= 8'h00;
		end
		else
		begin
			strobe <= {strobe[SAMPLE_PIPE-2:0], rise};
			if (strobe[SAMPLE_PIPE-1])
				rxs <= dual ? {rxs[5:0], pins_i} : {rxs[6:0], pins_i[1]};
		end
	end

	property p_sck_idle;
		@(posedge link_clk_i) disable iff (rst_i) cs_n_o |-> !sck_o;
	endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("clock high while deselected");

	property p_dual_release;
		@(posedge link_clk_i) disable iff (rst_i)
		(start && xfer.op == OP_DUAL) |=> do_oe_n_o && remaining == DUAL_CLOCKS;
	endproperty
	a_dual_release: assert property (p_dual_release) else $error("dual byte setup wrong");
endmodule : sfc_shifter

// ===== logic/sfc_flash_ctrl.sv
// Serial flash controller: fetch path, fetch cache and command mode
// Summary of operation
// - dual read sends programmed opcode then address
// - address bits 23..17 zero, rest from processor
// - one dummy byte precedes read data
// - dual byte takes four clocks, two lines
// - each fetched data byte raises ready with data
// - sequential next address fetches one more byte
// - non-sequential address deselects the flash
// - 32-byte fetch cache with base and length
// - jump loads base; fetched bytes fill cache
// - past 32 bytes the base slides forward
// - cached jump answered in one clock from idle; streaming deselects first
// - eight-byte command, response buffers and length
// - launch selects flash, runs length times eight clocks
// - up to eight bytes after the first go to responses
// - bytes beyond command buffer send don't-care
// - processor writes become flash transfers too
// - identity read 0x9F leaves three response bytes
// - command transfer end deselects the flash
// - single mode uses 0x0B, eight-clock bytes
// - enabled after reset until disable set
`timescale 1ns/1ns
module sfc_flash_ctrl
	import sfc_pkg::*;
#(
	parameter int LEN_W = 4
) (
	input  wire logic               clock_i,          // Core clock
	input  wire logic               rst_i,            // Async reset
	input  wire logic               link_clk_i,       // Link clock
	input  wire logic               ext_req_i,        // Access pulse
	input  wire logic               ext_we_i,         // Access is write
	input  wire logic [XADDR_W-1:0] ext_addr_i,       // Access address
	input  wire logic [7:0]         ext_wdata_i,      // Write data
	output logic      [7:0]         ext_rdata_o,      // Read data
	output logic                    ext_ready_o,      // Access done pulse
	input  wire logic               dual_mode_i,      // Dual read mode
	input  wire logic [7:0]         fast_read_opcode_reg_i, // Dual opcode
	input  wire logic               flash_disable_i,  // Interface off
	input  wire logic               cmd_buf_wr_i,     // Command byte write
	input  wire logic [2:0]         cmd_buf_idx_i,    // Command byte index
	input  wire logic [7:0]         cmd_buf_data_i,   // Command byte value
	input  wire logic [LEN_W-1:0]   transfer_byte_count_i, // Bytes to run
	input  wire logic               launch_i,         // Launch pulse
	output logic                    launch_busy_o,    // Launch bit
	output logic      [63:0]        response_buffer_o, // Response bytes
	output logic                    flash_sck_o,      // Serial clock
	output logic                    flash_cs_n_o,     // Chip select
	output logic                    flash_do_o,       // Out line value
	output logic                    flash_do_oe_n_o,  // Out line enable
	input  wire logic               flash_do_i,       // Out line readback
	input  wire logic               serial_in_line_i  // In line
);
	typedef enum logic [8:0]
	{
		ST_IDLE   = 9'h001,
		ST_OPC    = 9'h002,
		ST_ADDR   = 9'h004,
		ST_DUMMY  = 9'h008,
		ST_DATA   = 9'h010,
		ST_STREAM = 9'h020,
		ST_WDATA  = 9'h040,
		ST_CMD    = 9'h080,
		ST_END    = 9'h100
	} state_type;

	state_type          state;
	link_op_type        next_op;
	logic [7:0]         next_tx;
	logic               busy;
	logic               ack_seen;
	logic               ack_last;
	logic               byte_done;
	logic               issue;
	logic               req_seen;
	logic [1:0]         pins_seen;
	logic               pend;
	logic               cur_we;
	logic [XADDR_W-1:0] cur_addr;
	logic [XADDR_W-1:0] last_addr;
	logic [XADDR_W-1:0] cache_base;
	logic [XADDR_W-1:0] hit_offset;
	logic [7:0]         cur_wdata;
	logic [7:0]         cache_rd;
	logic [7:0]         cache_mem [CACHE_BYTES];
	logic [5:0]         cache_fill;
	logic               dual;
	logic               is_write;
	logic               cmd_run;
	logic [1:0]         addr_cnt;
	logic [LEN_W-1:0]   cmd_idx;
	logic [LEN_W-1:0]   len_q;
	logic [63:0]        cmd_buf;
	logic               hit;
	logic               seq_next;
	logic               take_off;
	logic               take_hit;
	logic               take_jump;
	logic               take_write;
	logic               launch_take;
	logic               data_done;
	logic               wdata_done;
	logic               cmd_last;

	sfc_xfer_if xfer ();

	if (LEN_W < 4 || LEN_W > 8)
	begin : g_bad_len
		$error("sfc_flash_ctrl: LEN_W must be 4 to 8");
	end

	sfc_sync #(.WIDTH(1)) ack_sync (
		.clk_i   (clock_i),
		.rst_i   (rst_i),
		.async_i (xfer.ack_tgl),
		.sync_o  (ack_seen)
	);

	sfc_sync #(.WIDTH(1)) req_sync (
		.clk_i   (link_clk_i),
		.rst_i   (rst_i),
		.async_i (xfer.req_tgl),
		.sync_o  (req_seen)
	);

	sfc_sync #(.WIDTH(2)) pin_sync (
		.clk_i   (link_clk_i),
		.rst_i   (rst_i),
		.async_i ({serial_in_line_i, flash_do_i}),
		.sync_o  (pins_seen)
	);

	sfc_shifter shifter (
		.link_clk_i (link_clk_i),
		.rst_i      (rst_i),
		.req_seen_i (req_seen),
		.pins_i     (pins_seen),
		.xfer       (xfer.link),
		.sck_o      (flash_sck_o),
		.cs_n_o     (flash_cs_n_o),
		.do_o       (flash_do_o),
		.do_oe_n_o  (flash_do_oe_n_o)
	);

	assign byte_done  = busy && (ack_seen != ack_last);
	assign issue      = !busy && state != ST_IDLE && state != ST_STREAM;
	assign hit_offset = cur_addr - cache_base;
	assign hit        = hit_offset < {{(XADDR_W-6){1'b0}}, cache_fill};
	assign cache_rd   = cache_mem[cur_addr[CACHE_IDX_W-1:0]];
	assign seq_next   = !cur_we && cur_addr == last_addr + 1'b1 && !flash_disable_i;
	assign take_off   = state == ST_IDLE && pend && flash_disable_i;
	assign take_hit   = state == ST_IDLE && pend && !flash_disable_i && !cur_we && hit;
	assign take_jump  = state == ST_IDLE && pend && !flash_disable_i && !cur_we && !hit;
	assign take_write = state == ST_IDLE && pend && !flash_disable_i && cur_we;
	assign launch_take = state == ST_IDLE && !pend && launch_i && !flash_disable_i;
	assign data_done  = state == ST_DATA && byte_done;
	assign wdata_done = state == ST_WDATA && byte_done;
	assign cmd_last   = cmd_idx == len_q - 1'b1;

	always_comb
	begin
		next_op = OP_SINGLE;
		next_tx = DUMMY_BYTE;
		case (state)
			ST_OPC:
				// dual opcode from register; single is fixed
				if (is_write)
					next_tx = BYTE_PROGRAM_OPCODE;
				else if (dual)
					next_tx = fast_read_opcode_reg_i;
				else
					next_tx = SINGLE_READ_OPCODE;
			ST_ADDR:
				// top seven address bits forced low
				case (addr_cnt)
					2'h0:    next_tx = {7'h00, cur_addr[XADDR_W-1]};
					2'h1:    next_tx = cur_addr[15:8];
					default: next_tx = cur_addr[7:0];
				endcase
			ST_DATA:
			begin
				next_tx = DONT_CARE_BYTE;
				next_op = dual ? OP_DUAL : OP_SINGLE;
			end
			ST_WDATA: next_tx = cur_wdata;
			ST_CMD:
				// past the buffer, don't-care bytes go out
				if (cmd_idx < CMD_BUF_BYTES)
					next_tx = cmd_buf[{cmd_idx[2:0], 3'h0} +: 8];
				else
					next_tx = DONT_CARE_BYTE;
			ST_END: next_op = OP_END;
			default: next_op = OP_SINGLE;
		endcase
	end

	// Each byte is one toggle out and one toggle back
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state        <= ST_IDLE;
			busy         <= 1'b0;
			ack_last     <= 1'b0;
			xfer.req_tgl <= 1'b0;
			xfer.op      <= OP_SINGLE;
			xfer.tx_byte <= 8'h00;
			dual         <= 1'b0;
			is_write     <= 1'b0;
			addr_cnt     <= 2'h0;
			cmd_idx      <= '0;
			len_q        <= '0;
			cmd_run      <= 1'b0;
		end
		else
		begin
			ack_last <= ack_seen;
			if (issue)
			begin
				xfer.req_tgl <= ~xfer.req_tgl;
				xfer.op      <= next_op;
				xfer.tx_byte <= next_tx;
				busy         <= 1'b1;
			end
			if (byte_done)
				busy <= 1'b0;
			case (state)
				ST_IDLE:
					if (take_jump)
					begin
						dual     <= dual_mode_i;
						is_write <= 1'b0;
						state    <= ST_OPC;
					end
					// writes run opcode, address and data
					else if (take_write)
					begin
						is_write <= 1'b1;
						state    <= ST_OPC;
					end
					// one byte per eight clocks, len bytes
					else if (launch_take)
					begin
						cmd_run <= 1'b1;
						cmd_idx <= '0;
						len_q   <= transfer_byte_count_i;
						state   <= (transfer_byte_count_i == '0) ? ST_END : ST_CMD;
					end
				ST_OPC:
					if (byte_done)
					begin
						addr_cnt <= 2'h0;
						state    <= ST_ADDR;
					end
				ST_ADDR:
					if (byte_done)
					begin
						if (addr_cnt == LAST_ADDR_BYTE)
							state <= is_write ? ST_WDATA : ST_DUMMY;
						else
							addr_cnt <= addr_cnt + 2'h1;
					end
				ST_DUMMY:
					if (byte_done)
						state <= ST_DATA;
				ST_DATA:
					if (byte_done)
						state <= ST_STREAM;
				ST_STREAM:
					if (pend)
						state <= seq_next ? ST_DATA : ST_END;
				ST_WDATA:
					if (byte_done)
						state <= ST_END;
				ST_CMD:
					if (byte_done)
					begin
						if (cmd_last)
							state <= ST_END;
						else
							cmd_idx <= cmd_idx + 1'b1;
					end
				ST_END:
					if (byte_done)
					begin
						state   <= ST_IDLE;
						cmd_run <= 1'b0;
					end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// A new access wins over the consume of the previous one
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pend      <= 1'b0;
			cur_we    <= 1'b0;
			cur_addr  <= '0;
			cur_wdata <= 8'h00;
		end
		else if (ext_req_i)
		begin
			pend      <= 1'b1;
			cur_we    <= ext_we_i;
			cur_addr  <= ext_addr_i;
			cur_wdata <= ext_wdata_i;
		end
		else if (take_off || take_hit || take_jump || take_write ||
			(state == ST_STREAM && pend && seq_next))
			pend <= 1'b0;
	end

	// one byte handed over per ready pulse
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ext_ready_o <= 1'b0;
			ext_rdata_o <= 8'h00;
		end
		else
		begin
			ext_ready_o <= take_off || take_hit || data_done || wdata_done;
			if (take_off)
				ext_rdata_o <= DISABLED_READ_BYTE;
			// cached jump answered without the flash
			else if (take_hit)
				ext_rdata_o <= cache_rd;
			else if (data_done)
				ext_rdata_o <= xfer.rx_byte;
		end
	end

	// window is cache_base up to cache_base plus cache_fill
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cache_base <= '0;
			cache_fill <= 6'h00;
			last_addr  <= '0;
		end
		else if (take_jump)
		begin
			cache_base <= cur_addr;
			cache_fill <= 6'h00;
		end
		// Flash contents may change under a write, so drop the window
		else if (take_write)
			cache_fill <= 6'h00;
		else if (data_done)
		begin
			last_addr <= cur_addr;
			if (cache_fill == CACHE_FULL)
				cache_base <= cache_base + 1'b1;
			else
				cache_fill <= cache_fill + 6'h01;
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (data_done)
			cache_mem[cur_addr[CACHE_IDX_W-1:0]] <= xfer.rx_byte;
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cmd_buf           <= BUF_RESET;
			response_buffer_o <= BUF_RESET;
			launch_busy_o     <= 1'b0;
		end
		else
		begin
			if (cmd_buf_wr_i)
				cmd_buf[{cmd_buf_idx_i, 3'h0} +: 8] <= cmd_buf_data_i;
			// up to eight bytes after the opcode are kept
			if (state == ST_CMD && byte_done && cmd_idx != '0 && cmd_idx <= CMD_BUF_BYTES)
				response_buffer_o[{cmd_idx[2:0] - 3'h1, 3'h0} +: 8] <= xfer.rx_byte;
			// launch bit drops with the deselect
			if (launch_take)
				launch_busy_o <= 1'b1;
			else if (state == ST_END && byte_done && cmd_run)
				launch_busy_o <= 1'b0;
		end
	end

	sequence s_addr_last;
		state == ST_ADDR && byte_done && addr_cnt == LAST_ADDR_BYTE && !is_write;
	endsequence
	sequence s_dummy_out;
		state == ST_DUMMY ##1 xfer.tx_byte == DUMMY_BYTE;
	endsequence
	property p_dummy;
		@(posedge clock_i) disable iff (rst_i) s_addr_last |=> s_dummy_out;
	endproperty
	a_dummy: assert property (p_dummy) else $error("no dummy after address");

	property p_dual_opc;
		@(posedge clock_i) disable iff (rst_i) (state == ST_OPC && issue && dual && !is_write)
		|=> xfer.tx_byte == $past(fast_read_opcode_reg_i);
	endproperty
	a_dual_opc: assert property (p_dual_opc) else $error("wrong dual opcode");

	property p_addr_top;
		@(posedge clock_i) disable iff (rst_i) (state == ST_ADDR && issue && addr_cnt == 2'h0)
		|=> xfer.tx_byte == {7'h00, $past(cur_addr[XADDR_W-1])};
	endproperty
	a_addr_top: assert property (p_addr_top) else $error("high address byte wrong");

	property p_ready;
		@(posedge clock_i) disable iff (rst_i)
		data_done |=> ext_ready_o && ext_rdata_o == $past(xfer.rx_byte);
	endproperty
	a_ready: assert property (p_ready) else $error("read byte not handed over");

	sequence s_seq_req;
		state == ST_STREAM && pend && seq_next;
	endsequence
	property p_seq;
		@(posedge clock_i) disable iff (rst_i) s_seq_req |=> state == ST_DATA ##1 busy;
	endproperty
	a_seq: assert property (p_seq) else $error("sequential fetch not continued");

	property p_nonseq;
		@(posedge clock_i) disable iff (rst_i) (state == ST_STREAM && pend && !seq_next)
		|=> state == ST_END ##1 xfer.op == OP_END;
	endproperty
	a_nonseq: assert property (p_nonseq) else $error("jump did not deselect");

	property p_slide;
		@(posedge clock_i) disable iff (rst_i) (data_done && cache_fill == CACHE_FULL)
		|=> cache_base == $past(cache_base) + 1'b1 && cache_fill == CACHE_FULL;
	endproperty
	a_slide: assert property (p_slide) else $error("cache window did not slide");

	property p_hit;
		@(posedge clock_i) disable iff (rst_i)
		take_hit |=> ext_ready_o && ext_rdata_o == $past(cache_rd) && !busy;
	endproperty
	a_hit: assert property (p_hit) else $error("cache hit not served");

	property p_excess;
		@(posedge clock_i) disable iff (rst_i) (state == ST_CMD && issue && cmd_idx >= CMD_BUF_BYTES)
		|=> xfer.tx_byte == DONT_CARE_BYTE;
	endproperty
	a_excess: assert property (p_excess) else $error("excess byte not don't-care");

	property p_launch_clear;
		@(posedge clock_i) disable iff (rst_i)
		(state == ST_END && byte_done && cmd_run) |=> !launch_busy_o && state == ST_IDLE;
	endproperty
	a_launch_clear: assert property (p_launch_clear) else $error("launch bit stuck");
endmodule : sfc_flash_ctrl

// ===== tb/sfc_flash_model.sv
// Behavioural serial flash answering reads, commands and identity reads
`timescale 1ns/1ns
module sfc_flash_model #(
	parameter logic [23:0] ID = 24'h13_579A // Arbitrary identity value
) (
	input  wire logic sck_i,  // Serial clock
	input  wire logic cs_n_i, // Chip select
	input  wire logic io0_i,  // Out line level
	output logic      di_o,   // In line drive
	output logic      io0_o   // Out line drive
);
	logic [63:0] sh = 0;
	logic [7:0]  op = 0, q;
	logic [23:0] addr = 0;
	int          nclk = 0;
	function automatic logic [7:0] mem(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
	endfunction : mem
	initial {di_o, io0_o} = 2'b01;
	// Released lines must not hold a stale value
	always @(posedge cs_n_i) {di_o, io0_o} <= ~{di_o, io0_o};
	always @(negedge cs_n_i) nclk <= 0;
	always @(posedge sck_i)
	begin
		sh <= {sh[62:0], io0_i};
		nclk <= nclk + 1;
		if (nclk == 7) op <= {sh[6:0], io0_i};
		if (nclk == 31) addr <= {sh[22:0], io0_i};
	end
	always @(negedge sck_i)
	begin
		if (op == 8'h9F && nclk >= 8 && nclk < 32)
			di_o <= ID[31 - nclk];
		else if (op == 8'h0B && nclk >= 40)
		begin
			q = mem(addr + 24'((nclk - 40) / 8));
			di_o <= q[7 - nclk % 8];
		end
		else if (op == 8'h3B && nclk >= 40)
		begin
			q = mem(addr + 24'((nclk - 40) / 4));
			{di_o, io0_o} <= q[7 - 2 * (nclk % 4) -: 2];
		end
		else
			{di_o, io0_o} <= ~{di_o, io0_o};
	end
endmodule : sfc_flash_model

// ===== tb/tb.sv
// Self-checking bench for the serial flash controller
`timescale 1ns/1ns
module tb;
	import sfc_pkg::*;
	typedef struct packed {logic [16:0] a; logic d; logic hit;} row_type;
	logic        clk = 0, lclk = 0, rst = 1, req = 0, we = 0, dual = 0, dis = 0;
	logic        cwr = 0, go = 0, ready, busy, sck, cs_n, dout, oe_n, din, io0;
	logic [16:0] addr = 0;
	logic [7:0]  wd = 8'h5C, rdata, cdat = 0;
	logic [2:0]  cidx = 0;
	logic [3:0]  len = 0;
	logic [63:0] resp;
	logic [7:0]  ers [3] = '{8'h20, 8'h52, 8'hD8};
	row_type     rows [7] = '{'{17'h0_0100, 0, 0}, '{17'h0_0101, 0, 0},
		'{17'h0_0102, 0, 0}, '{17'h0_0100, 0, 1}, '{17'h1_F000, 1, 0},
		'{17'h1_F001, 1, 0}, '{17'h1_F000, 1, 1}};
	int          n_errors = 0, n_compared = 0, n_sck = 0;
	wire         line = oe_n ? io0 : dout;
	always #25 clk = ~clk;
	always #6 lclk = ~lclk;
	// A cache hit must leave the flash clock untouched
	always @(posedge sck) n_sck++;
	sfc_flash_ctrl #(.LEN_W(4)) i_dut (
		.clock_i(clk), .rst_i(rst), .link_clk_i(lclk), .ext_req_i(req), .ext_we_i(we),
		.ext_addr_i(addr), .ext_wdata_i(wd), .ext_rdata_o(rdata), .ext_ready_o(ready),
		.dual_mode_i(dual), .fast_read_opcode_reg_i(8'h3B), .flash_disable_i(dis),
		.cmd_buf_wr_i(cwr), .cmd_buf_idx_i(cidx), .cmd_buf_data_i(cdat),
		.transfer_byte_count_i(len), .launch_i(go), .launch_busy_o(busy),
		.response_buffer_o(resp), .flash_sck_o(sck), .flash_cs_n_o(cs_n),
		.flash_do_o(dout), .flash_do_oe_n_o(oe_n), .flash_do_i(line),
		.serial_in_line_i(din));
	sfc_flash_model i_flash (.sck_i(sck), .cs_n_i(cs_n), .io0_i(line), .di_o(din),
		.io0_o(io0));
	function automatic logic [7:0] mem(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'hA5;
	endfunction : mem
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (e !== g)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick
	// Every wait is bounded so a stuck handshake ends the run
	task automatic guard(input int i);
		if (i > 3000)
		begin
			n_errors++;
			final_report();
		end
	endtask : guard
	task automatic rd(input logic [16:0] a, input logic d, input logic hit, input logic w);
		int lat, s0;
		{req, we, addr, dual} = {1'b1, w, a, d};
		lat = 0;
		s0 = n_sck;
		do
		begin
			tick();
			req = 0;
			lat++;
			guard(lat);
		end while (ready !== 1'b1);
		if (!w) chk("rdata", dis ? 8'hFF : mem({7'h00, a}), rdata);
		chk("hit", hit, n_sck == s0);
		if (!w) chk("release", d && !hit, oe_n);
		if (hit) chk("deselect", 1, cs_n);
	endtask : rd
	task automatic run(input logic [3:0] n, input logic [63:0] b);
		int i;
		for (i = 0; i < 8; i++)
		begin
			{cwr, cidx, cdat} = {1'b1, 3'(i), b[63 - 8 * i -: 8]};
			tick();
		end
		{cwr, len, go} = {1'b0, n, 1'b1};
		tick();
		go = 0;
		tick();
		i = 0;
		do
		begin
			tick();
			i++;
			guard(i);
		end while (busy !== 1'b0);
		chk("clocks", 8 * n, i_flash.nclk);
		chk("select", 1, cs_n);
	endtask : run
	initial
	begin
		repeat (2) tick();
		rst = 0;
		chk("idle", 4'b1000, {cs_n, sck, busy, ready});
		foreach (rows[i]) rd(rows[i].a, rows[i].d, rows[i].hit, 0);
		for (int i = 0; i < 40; i++) rd(17'h0_0300 + 17'(i), 0, 0, 0);
		rd(17'h0_0310, 0, 1, 0);
		rd(17'h0_0307, 0, 0, 0);
		rd(17'h0_0307, 0, 1, 0);
		foreach (ers[i])
		begin
			run(4, {ers[i], 56'h12_3456_0000_0000});
			chk("erase", {ers[i], 24'h12_3456}, i_flash.sh[31:0]);
		end
		run(5, 64'h0212_3456_A700_0000);
		chk("program", 40'h02_1234_56A7, i_flash.sh[39:0]);
		run(1, 64'h0600_0000_0000_0000);
		chk("single", 8'h06, i_flash.sh[7:0]);
		run(4, 64'h9F00_0000_0000_0000);
		chk("ident", {i_flash.ID[7:0], i_flash.ID[15:8], i_flash.ID[23:16]},
			resp[23:0]);
		run(10, 64'h0000_0000_0000_0000);
		chk("excess", 16'hFFFF, i_flash.sh[15:0]);
		rd(17'h0_1234, 0, 0, 1);
		chk("write", 40'h02_0012_345C, i_flash.sh[39:0]);
		dis = 1;
		rd(17'h0_0400, 0, 1, 0);
		go = 1;
		tick();
		go = 0;
		repeat (3) tick();
		chk("ignored", 0, busy);
		dis = 0;
		go = 1;
		tick();
		go = 0;
		repeat (10) tick();
		chk("running", 2'b01, {cs_n, busy});
		rst = 1;
		tick();
		tick();
		rst = 0;
		chk("reset", 5'b10000, {cs_n, sck, busy, ready, oe_n});
		chk("response", 0, resp);
		rd(17'h0_0500, 0, 0, 0);
		final_report();
	end
endmodule : tb
